// ===== hdl/lsd_top.v
// Segment LCD driver control, status, clocking and pixel store
//
// Operation
// - Clock from sys/8192, timer1/32 or slow/32
// - Sys divider fixed; prescaler does rate trim
// - Oscillator sources keep panel running in sleep unless sleep-stop set
// - Four-bit prescaler, ratios 1:1 to 1:16
// - Prescaler counter has no software access
// - Prescale ratio equals field value plus one
// - Type B flips per frame, A per tick
// - Two/three commons: bit one half, else third
// - Read-only active flag shows driver running
// - Read-only write-allow flag gates pixel writes
// - Segment enable bit: one LCD, zero I/O
// - Pixel bit one dark; power-up unknown
// - Module enable switches driver on and off
// - Sleep-stop bit set halts driver in sleep
// - Commons select 1..4 commons, resets four
// - Bias pin enable set after reset
//
// Map: 0 control, 1 phase and prescale, 2-3 segment enables,
// 4-11 pixel words, two per common, low segments first
//
// Chosen here: the register offsets and the strobed register port.
`default_nettype none
`include "lsd_consts.vh"

module lsd_top
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_n_i,
    // Register port
    input  wire [3:0]  addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    // System state and oscillator pins
    input  wire        sleep_i,
    input  wire        t1_osc_i,
    input  wire        lf_osc_i,
    // Panel side
    output wire [15:0] segment_pin_sel_o,
    output wire [3:0]  com_pin_use_o,
    output wire        bias_pin_on_o,
    output wire        bias_static_o,
    output wire        bias_half_o,
    output wire        lcd_tick_o,
    output reg  [1:0]  com_idx_o,
    output reg         phase_o,
    output reg  [15:0] seg_data_o
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    reg        driver_on_q;
    reg        sleep_stop_q;
    reg        write_fail_flag_q;
    reg        bias_pin_on_q;
    reg  [1:0] clk_sel_q;
    reg  [1:0] commons_sel_q;
    reg        waveform_kind_q;
    reg        bias_choice_q;
    reg  [3:0] prescale_sel_q;
    reg  [7:0] segen_q [0:1];
    reg  [7:0] pix_q [0:7];
    reg  [7:0] rd_mux_d;

    // Reset words, split into their fields below
    localparam [7:0] CTRL_RST = `LSD_CTRL_RST;
    localparam [7:0] PS_RST   = `LSD_PS_RST;

    wire       hit_ctrl;
    wire       hit_ps;
    wire       hit_seg0;
    wire       hit_seg1;
    wire       hit_pix;
    wire [7:0] fetch_lo;
    wire [7:0] fetch_hi;
    wire       wr_ctrl;
    wire       wr_ps;
    wire       wr_pix;
    wire [2:0] pix_idx;
    wire       sys_run;
    wire       osc_run;
    wire       driver_active_flag;
    wire       write_allow_flag;
    wire       src_tick;

    assign hit_ctrl = (addr_i == `LSD_ADDR_CTRL);
    assign hit_ps   = (addr_i == `LSD_ADDR_PHASE);
    assign hit_seg0 = (addr_i == `LSD_ADDR_SEGEN0);
    assign hit_seg1 = (addr_i == `LSD_ADDR_SEGEN1);
    // Words above the pixel store are unmapped and read as zero
    assign hit_pix  = (addr_i >= `LSD_ADDR_PIX_LO) && (addr_i <= `LSD_ADDR_PIX_HI);
    assign wr_ctrl  = wr_i && hit_ctrl;
    assign wr_ps    = wr_i && hit_ps;
    assign wr_pix   = wr_i && hit_pix;
    assign pix_idx  = addr_i[2:0] - 3'h4;

    // ----------------------------------------------------------------
    // Run and status
    // ----------------------------------------------------------------
    // The system source dies in sleep; the slow oscillators survive it unless sleep-stop is set
    assign sys_run = driver_on_q && !sleep_i;
    assign osc_run = driver_on_q && !(sleep_i && sleep_stop_q);
    assign driver_active_flag = (clk_sel_q == `LSD_CS_SYS) ? sys_run : osc_run;
    // Writes are refused only in the cycle the frame fetches pixel data
    // Trade-off: software is almost never held off, but a write that
    // meets the fetch cycle is lost and only the error flag tells
    assign write_allow_flag = !(driver_active_flag && lcd_tick_o);

    // ----------------------------------------------------------------
    // Control and phase registers
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            driver_on_q       <= CTRL_RST[`LSD_CTRL_ON];
            sleep_stop_q      <= CTRL_RST[`LSD_CTRL_SLEEP];
            write_fail_flag_q <= CTRL_RST[`LSD_CTRL_WRITE_FAIL_FLAG];
            bias_pin_on_q     <= CTRL_RST[`LSD_CTRL_BIASPIN];
            clk_sel_q         <= CTRL_RST[`LSD_CTRL_CS_HI:`LSD_CTRL_CS_LO];
            commons_sel_q     <= CTRL_RST[`LSD_CTRL_MUX_HI:`LSD_CTRL_MUX_LO];
            waveform_kind_q   <= PS_RST[`LSD_PS_WAVE];
            bias_choice_q     <= PS_RST[`LSD_PS_BIAS];
            prescale_sel_q    <= PS_RST[`LSD_PS_LP_HI:`LSD_PS_LP_LO];
        end
        else
        begin
            // The error bit is left out here: a written one must not set it
            if (wr_ctrl)
            begin
                driver_on_q   <= wdata_i[`LSD_CTRL_ON];
                sleep_stop_q  <= wdata_i[`LSD_CTRL_SLEEP];
                bias_pin_on_q <= wdata_i[`LSD_CTRL_BIASPIN];
                clk_sel_q     <= wdata_i[`LSD_CTRL_CS_HI:`LSD_CTRL_CS_LO];
                commons_sel_q <= wdata_i[`LSD_CTRL_MUX_HI:`LSD_CTRL_MUX_LO];
            end
            // Set wins over clear; software can only clear the flag
            if (wr_pix && !write_allow_flag)
                write_fail_flag_q <= 1'b1;
            else if (wr_ctrl && !wdata_i[`LSD_CTRL_WRITE_FAIL_FLAG])
                write_fail_flag_q <= 1'b0;
            if (wr_ps)
            begin
                waveform_kind_q <= wdata_i[`LSD_PS_WAVE];
                bias_choice_q   <= wdata_i[`LSD_PS_BIAS];
                prescale_sel_q  <= wdata_i[`LSD_PS_LP_HI:`LSD_PS_LP_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // Segment enables and pixel store
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            segen_q[0] <= `LSD_SEGEN_RST;
            segen_q[1] <= `LSD_SEGEN_RST;
        end
        else if (wr_i && hit_seg0)
            segen_q[0] <= wdata_i;
        else if (wr_i && hit_seg1)
            segen_q[1] <= wdata_i;
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_pix
            // Pixel storage has no reset: its content is unknown at power-up
            always @(posedge clk_i)
            begin
                if (wr_pix && write_allow_flag && (pix_idx == g))
                    pix_q[g] <= wdata_i;
            end
        end
    endgenerate

    // Enables reset to I/O, so no pin drives glass before software asks
    assign segment_pin_sel_o = {segen_q[1], segen_q[0]};

    // ----------------------------------------------------------------
    // Clocking
    // ----------------------------------------------------------------
    // Divider and prescaler clear whenever the driver stops,
    // so the first frame after a restart is a whole one
    lsd_src_div u_src
    (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .sys_run_i  (sys_run),
        .osc_run_i  (osc_run),
        .cs_i       (clk_sel_q),
        .t1_osc_i   (t1_osc_i),
        .lf_osc_i   (lf_osc_i),
        .src_tick_o (src_tick)
    );

    lsd_prescale u_ps
    (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .run_i       (driver_active_flag),
        .ratio_sel_i (prescale_sel_q),
        .src_tick_i  (src_tick),
        .lcd_tick_o  (lcd_tick_o)
    );

    // ----------------------------------------------------------------
    // Commons, bias and phase sequencing
    // ----------------------------------------------------------------
    // Common 0 always drives; higher commons join as the mux grows
    assign com_pin_use_o = {commons_sel_q == 2'h3, commons_sel_q >= 2'h2,
                            commons_sel_q != 2'h0, 1'b1};
    assign bias_pin_on_o = bias_pin_on_q;
    // Bias bit is ignored in static and four-common modes (software keeps it 0)
    assign bias_static_o = (commons_sel_q == 2'h0);
    assign bias_half_o   = bias_choice_q && (commons_sel_q == 2'h1 ||
                                             commons_sel_q == 2'h2);

    wire last_com;
    assign last_com = (com_idx_o == commons_sel_q);
    assign fetch_lo = pix_q[{com_idx_o, 1'b0}];
    assign fetch_hi = pix_q[{com_idx_o, 1'b1}];

    // Type A flips phase every tick and steps the common after the
    // second half, so each common sees both polarities back to back.
    // Type B keeps one phase for a frame and flips it at the wrap:
    // one phase flip per frame instead of one per tick, but each polarity lasts longer.
    // An enabled but inactive driver (sleep) freezes where it is.

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            com_idx_o  <= 2'h0;
            phase_o    <= 1'b0;
            seg_data_o <= 16'h0000;
        end
        else if (!driver_active_flag && !driver_on_q)
        begin
            com_idx_o  <= 2'h0;
            phase_o    <= 1'b0;
            seg_data_o <= 16'h0000;
        end
        else if (lcd_tick_o)
        begin
            if (waveform_kind_q)
            begin
                com_idx_o <= last_com ? 2'h0 : com_idx_o + 2'h1;
                if (last_com)
                    phase_o <= !phase_o;
            end
            else
            begin
                phase_o <= !phase_o;
                if (phase_o)
                    com_idx_o <= last_com ? 2'h0 : com_idx_o + 2'h1;
            end
            seg_data_o <= {fetch_hi, fetch_lo} & segment_pin_sel_o;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Status bits are taken live; unmapped words read as zero
    always @*
    begin
        rd_mux_d = 8'h00;
        if (hit_ctrl)
            rd_mux_d = {driver_on_q, sleep_stop_q, write_fail_flag_q, bias_pin_on_q,
                        clk_sel_q, commons_sel_q};
        else if (hit_ps)
            rd_mux_d = {waveform_kind_q, bias_choice_q, driver_active_flag,
                        write_allow_flag, prescale_sel_q};
        else if (hit_seg0)
            rd_mux_d = segen_q[0];
        else if (hit_seg1)
            rd_mux_d = segen_q[1];
        else if (hit_pix)
            rd_mux_d = pix_q[pix_idx];
    end

    // Read data stand for one cycle only and are zero otherwise
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= rd_mux_d;
        else
            rdata_o <= 8'h00;
    end

endmodule
`default_nettype wire

// ===== shared/lsd_consts.vh
// Constants for the segment LCD driver control block
`ifndef LSD_CONSTS_VH
`define LSD_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LSD_ADDR_CTRL     4'h0
`define LSD_ADDR_PHASE    4'h1
`define LSD_ADDR_SEGEN0   4'h2
`define LSD_ADDR_SEGEN1   4'h3
`define LSD_ADDR_PIX_LO   4'h4
`define LSD_ADDR_PIX_HI   4'hb

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LSD_CTRL_ON       7
`define LSD_CTRL_SLEEP    6
`define LSD_CTRL_WRITE_FAIL_FLAG     5
`define LSD_CTRL_BIASPIN  4
`define LSD_CTRL_CS_HI    3
`define LSD_CTRL_CS_LO    2
`define LSD_CTRL_MUX_HI   1
`define LSD_CTRL_MUX_LO   0

// ----------------------------------------------------------------
// Phase and prescale register fields
// ----------------------------------------------------------------
`define LSD_PS_WAVE       7
`define LSD_PS_BIAS       6
`define LSD_PS_ACTIVE     5
`define LSD_PS_WALLOW     4
`define LSD_PS_LP_HI      3
`define LSD_PS_LP_LO      0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSD_CTRL_RST      8'h13
`define LSD_PS_RST        8'h00
`define LSD_SEGEN_RST     8'h00

// ----------------------------------------------------------------
// Clock source encodings and fixed divisors
// ----------------------------------------------------------------
`define LSD_CS_SYS        2'h0
`define LSD_CS_T1         2'h1
`define LSD_SYS_DIV_MAX   13'h1fff
`define LSD_OSC_DIV_MAX   5'h1f

`endif

// ===== hdl/lsd_src_div.v
// Clock source selection and fixed source dividers of the LCD driver
`default_nettype none
`include "lsd_consts.vh"

module lsd_src_div
(
    // Clock and reset
    input  wire       clk_i,
    input  wire       reset_n_i,
    // Control
    input  wire       sys_run_i,
    input  wire       osc_run_i,
    input  wire [1:0] cs_i,
    // Oscillator pins
    input  wire       t1_osc_i,
    input  wire       lf_osc_i,
    // Source tick
    output wire       src_tick_o
);

    // ----------------------------------------------------------------
    // Oscillator synchronisers, one per slow oscillator
    // ----------------------------------------------------------------
    wire [1:0] osc_pin;
    wire [1:0] osc_rise;
    assign osc_pin = {lf_osc_i, t1_osc_i};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg lvl_q;
            always @(posedge clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    lvl_q <= 1'b0;
                end
                else
                begin
                    s1_q <= osc_pin[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // A level counts only once two stages agree
                    if (s2_q == s3_q)
                        lvl_q <= s3_q;
                end
            end
            assign osc_rise[g] = (s2_q == s3_q) && s3_q && !lvl_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Fixed dividers: system /8192, oscillator /32
    // ----------------------------------------------------------------
    reg  [12:0] sys_cnt_q;
    reg  [4:0]  osc_cnt_q;
    wire        use_sys;
    wire        osc_edge;
    assign use_sys  = (cs_i == `LSD_CS_SYS);
    assign osc_edge = (cs_i == `LSD_CS_T1) ? osc_rise[0] : osc_rise[1];

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sys_cnt_q <= 13'h0000;
            osc_cnt_q <= 5'h00;
        end
        else
        begin
            // The /8192 stage is fixed; rate trim comes only from the prescaler
            if (sys_run_i && use_sys)
                sys_cnt_q <= sys_cnt_q + 13'h0001;
            else
                sys_cnt_q <= 13'h0000;
            if (osc_run_i && !use_sys && osc_edge)
                osc_cnt_q <= osc_cnt_q + 5'h01;
            else if (!osc_run_i || use_sys)
                osc_cnt_q <= 5'h00;
        end
    end

    assign src_tick_o = use_sys ? (sys_run_i && sys_cnt_q == `LSD_SYS_DIV_MAX)
                                : (osc_run_i && osc_edge && osc_cnt_q == `LSD_OSC_DIV_MAX);

endmodule
`default_nettype wire

// ===== hdl/lsd_prescale.v
// Four-bit LCD clock prescaler, ratio select plus one
`default_nettype none
`include "lsd_consts.vh"

module lsd_prescale
(
    // Clock and reset
    input  wire       clk_i,
    input  wire       reset_n_i,
    // Control
    input  wire       run_i,
    input  wire [3:0] ratio_sel_i,
    input  wire       src_tick_i,
    // Divided tick
    output wire       lcd_tick_o
);

    // No software path reaches this counter
    reg [3:0] cnt_q;

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cnt_q <= 4'h0;
        else if (!run_i)
            cnt_q <= 4'h0;
        else if (src_tick_i)
        begin
            if (cnt_q >= ratio_sel_i)
                cnt_q <= 4'h0;
            else
                cnt_q <= cnt_q + 4'h1;
        end
    end

    assign lcd_tick_o = run_i && src_tick_i && (cnt_q >= ratio_sel_i);

endmodule
`default_nettype wire

// ===== verif/lsd_top_monitor.sv
// Port checker for the segment LCD driver control block
`default_nettype none

module lsd_top_monitor
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    // Register port
    input wire logic [3:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    // System state and panel side
    input wire logic        sleep_i,
    input wire logic [15:0] segment_pin_sel_o,
    input wire logic [3:0]  com_pin_use_o,
    input wire logic        bias_pin_on_o,
    input wire logic        bias_static_o,
    input wire logic        bias_half_o,
    input wire logic        lcd_tick_o,
    input wire logic [1:0]  com_idx_o,
    input wire logic        phase_o,
    input wire logic [15:0] seg_data_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Shadow of the software-written fields
    // ------------------------------------------------------------
    logic [7:0]  ctl_q;
    logic [7:0]  ps_q;
    logic [15:0] se_q;
    logic        act;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctl_q <= 8'h13;
            ps_q  <= 8'h00;
            se_q  <= 16'h0000;
        end
        else if (wr_i)
        begin
            if (addr_i == 4'h0)
                ctl_q <= wdata_i;
            if (addr_i == 4'h1)
                ps_q <= wdata_i;
            if (addr_i == 4'h2)
                se_q[7:0] <= wdata_i;
            if (addr_i == 4'h3)
                se_q[15:8] <= wdata_i;
        end
    end

    // Sleep only halts the system-clock source unless sleep-stop is set
    assign act = ctl_q[7] & ((ctl_q[3:2] == 2'h0) ? !sleep_i : !(sleep_i & ctl_q[6]));

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    bias_static_a: assert property (bias_static_o == (ctl_q[1:0] == 2'h0))
        else $error("static bias flag wrong");
    bias_half_a: assert property (
        bias_half_o == (ps_q[6] && (ctl_q[1:0] == 2'h1 || ctl_q[1:0] == 2'h2)))
        else $error("half bias flag wrong");
    com_use_a: assert property (
        com_pin_use_o == {ctl_q[1:0] == 2'h3, ctl_q[1], ctl_q[1:0] != 2'h0, 1'b1})
        else $error("commons in use wrong");
    seg_sel_a: assert property (segment_pin_sel_o == se_q)
        else $error("segment enables wrong");
    bias_pin_a: assert property (bias_pin_on_o == ctl_q[4])
        else $error("bias pin enable wrong");
    tick_pulse_a: assert property (lcd_tick_o |=> !lcd_tick_o [*8])
        else $error("frame tick too close");
    act_read_a: assert property (rd_i && addr_i == 4'h1 |=> rdata_o[5] == $past(act))
        else $error("active flag wrong");
    wa_read_a: assert property (
        rd_i && addr_i == 4'h1 |=> rdata_o[4] == !($past(act) && $past(lcd_tick_o)))
        else $error("write allow flag wrong");
    wave_a_a: assert property (
        act && !ps_q[7] && lcd_tick_o |=> phase_o != $past(phase_o))
        else $error("type A phase did not flip");
    wave_b_step_a: assert property (
        act && ps_q[7] && lcd_tick_o && com_idx_o != ctl_q[1:0]
        |=> com_idx_o == $past(com_idx_o) + 2'h1 && $stable(phase_o))
        else $error("type B step wrong");
    wave_b_wrap_a: assert property (
        act && ps_q[7] && lcd_tick_o && com_idx_o == ctl_q[1:0]
        |=> com_idx_o == 2'h0 && phase_o != $past(phase_o))
        else $error("type B wrap wrong");
    off_idle_a: assert property (
        !ctl_q[7] && !$past(ctl_q[7]) |-> com_idx_o == 2'h0 && !phase_o && seg_data_o == 16'h0000)
        else $error("driver off but panel busy");

    cover property (act && ps_q[7] && lcd_tick_o && com_idx_o == ctl_q[1:0]);
    cover property (act && wr_i && lcd_tick_o && addr_i >= 4'h4 && addr_i <= 4'hb);
    cover property (rd_i && addr_i == 4'h1 && sleep_i);
endmodule

bind lsd_top lsd_top_monitor lsd_top_monitor_i (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .sleep_i, .segment_pin_sel_o, .com_pin_use_o, .bias_pin_on_o,
    .bias_static_o, .bias_half_o, .lcd_tick_o, .com_idx_o, .phase_o, .seg_data_o);

`default_nettype wire

// ===== verif/lsd_panel_model.sv
// Far-side model: panel image of common 0 and the two slow oscillators
`default_nettype none

module lsd_panel_model
(
    // Clock
    input  wire logic        clk_i,
    // Panel drive
    input  wire logic        lcd_tick_i,
    input  wire logic [1:0]  com_idx_i,
    input  wire logic [15:0] seg_data_i,
    // Oscillators and seen image
    output var  logic        t1_osc_o,
    output var  logic        lf_osc_o,
    output var  logic [15:0] com0_dark_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic tick_d;

    // Crystals run free; odd offsets keep their edges off the system clock
    initial
    begin
        t1_osc_o = 1'b0;
        #37;
        forever #400 t1_osc_o = ~t1_osc_o;
    end

    initial
    begin
        lf_osc_o = 1'b0;
        #13;
        forever #500 lf_osc_o = ~lf_osc_o;
    end

    // A one bit is a dark pixel on the glass
    always @(posedge clk_i)
    begin
        tick_d <= lcd_tick_i;
        if (tick_d && com_idx_i == 2'h0)
            com0_dark_o <= seg_data_i;
    end
endmodule

`default_nettype wire

// ===== verif/lsd_top_tb.sv
// Self-checking bench of the segment LCD driver control block
`default_nettype none

module lsd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        sleep_i = 1'b0;
    logic        t1_osc_i;
    logic        lf_osc_i;
    logic [7:0]  rdata_o;
    logic [15:0] segment_pin_sel_o;
    logic [3:0]  com_pin_use_o;
    logic        bias_pin_on_o;
    logic        bias_static_o;
    logic        bias_half_o;
    logic        lcd_tick_o;
    logic [1:0]  com_idx_o;
    logic        phase_o;
    logic [15:0] seg_data_o;
    logic [15:0] com0_dark;
    logic [15:0] n;
    int          error_cnt = 0;
    int          num_checks = 0;
    logic [1:0]  cs_t [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0]  mux_t [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    logic [7:0]  ps_t [4] = '{8'h00, 8'h8f, 8'h41, 8'h8f};
    logic [15:0] per_t [4] = '{16'd8192, 16'd4096, 16'd640, 16'd5120};

    lsd_top lsd_top_i (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .sleep_i, .t1_osc_i, .lf_osc_i, .segment_pin_sel_o, .com_pin_use_o, .bias_pin_on_o,
        .bias_static_o, .bias_half_o, .lcd_tick_o, .com_idx_o, .phase_o, .seg_data_o);

    lsd_panel_model lsd_panel_model_i (.clk_i, .lcd_tick_i(lcd_tick_o), .com_idx_i(com_idx_o),
        .seg_data_i(seg_data_o), .t1_osc_o(t1_osc_i), .lf_osc_o(lf_osc_i),
        .com0_dark_o(com0_dark));

    always #50 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Register port and checking tasks
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, rdata_o});
    endtask

    // Returns at the falling edge inside a tick cycle
    task automatic wait_tick;
        int k = 0;
        @(negedge clk_i);
        while (lcd_tick_o !== 1'b1 && k < 20000)
        begin
            @(negedge clk_i);
            k++;
        end
    endtask

    task automatic meas(output logic [15:0] p);
        wait_tick();
        p = 16'h0000;
        do
        begin
            @(negedge clk_i);
            p++;
        end while (lcd_tick_o !== 1'b1 && p < 16'hffff);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rc(4'h0, 8'h13);
        rc(4'h1, 8'h10);
        rc(4'h2, 8'h00);
        reg_wr(4'hc, 8'hff);
        rc(4'hc, 8'h00);
        reg_wr(4'h2, 8'ha5);
        reg_wr(4'h3, 8'h3c);
        rc(4'h3, 8'h3c);
        chk("segment enables", 16'h3ca5, segment_pin_sel_o);
        reg_wr(4'h0, 8'h23);
        rc(4'h0, 8'h03);
        for (int m = 0; m < 4; m++)
        begin
            // Bias bit stays clear in static and four-common modes
            reg_wr(4'h1, {1'b0, m == 1 || m == 2, 6'h00});
            reg_wr(4'h0, {6'h00, m[1:0]});
            @(negedge clk_i);
            chk("static bias", {15'h0, m == 0}, {15'h0, bias_static_o});
            chk("half bias", {15'h0, m == 1 || m == 2}, {15'h0, bias_half_o});
        end
        $display("test registers done");

        reg_wr(4'h2, 8'hff);
        reg_wr(4'h3, 8'hff);
        reg_wr(4'h4, 8'hf0);
        reg_wr(4'h5, 8'h0f);
        rc(4'h4, 8'hf0);
        reg_wr(4'h1, 8'h00);
        reg_wr(4'h0, 8'h80);
        rc(4'h1, 8'h30);
        wait_tick();
        // Next tick edge is one full tick period, 8192 system clocks, away
        repeat (8191) @(posedge clk_i);
        reg_wr(4'h4, 8'h00);
        rc(4'h0, 8'ha0);
        rc(4'h4, 8'hf0);
        chk("panel image", 16'h0ff0, com0_dark);
        reg_wr(4'h0, 8'h80);
        rc(4'h0, 8'h80);
        $display("test pixels done");

        @(posedge clk_i);
        sleep_i <= 1'b1;
        rc(4'h1, 8'h10);
        reg_wr(4'h0, 8'h84);
        rc(4'h1, 8'h30);
        reg_wr(4'h0, 8'hc4);
        rc(4'h1, 8'h10);
        @(posedge clk_i);
        sleep_i <= 1'b0;
        $display("test sleep done");

        for (int i = 0; i < 4; i++)
        begin
            reg_wr(4'h1, ps_t[i]);
            reg_wr(4'h0, {4'h8, cs_t[i], mux_t[i]});
            meas(n);
            meas(n);
            chk("tick period", per_t[i], n);
        end
        $display("test clocks done");
        end_sim();
    end

    initial
    begin
        // Pixel test about two system periods, clock table about 72000 cycles
        repeat (95000) @(posedge clk_i);
        error_cnt++;
        end_sim();
    end
endmodule

`default_nettype wire
